/* smdc_map.svh */
/*
  Named constants for the step motor drive control block.
  Assumes it is included by bare name and holds only definitions.
*/
`ifndef SMDC_MAP_SVH
`define SMDC_MAP_SVH
`define SMDC_CLK_HZ        40000000
`define SMDC_IDLE_MS       100
`define SMDC_IDLE_CYCLES   ((`SMDC_CLK_HZ / 1000) * `SMDC_IDLE_MS)
`define SMDC_BAUD          9600
`define SMDC_BIT_CYCLES    (`SMDC_CLK_HZ / `SMDC_BAUD)
`define SMDC_RATE_WIN      `SMDC_CLK_HZ
`define SMDC_RATE_SHIFT    4
`define SMDC_CMD_JOG       8'h42
`define SMDC_CMD_DECAY     8'h62
`define SMDC_CMD_CLEAR     8'h43
`define SMDC_CMD_DIV       8'h44
`define SMDC_CMD_INIT      8'h49
`define SMDC_CMD_ACCEL     8'h4b
`define SMDC_CMD_TEST      8'h4d
`define SMDC_CMD_STORE     8'h53
`define SMDC_CMD_EXAM      8'h58
`define SMDC_DEF_JOG0      16'h0190
`define SMDC_DEF_JOG1      16'h0fa0
`define SMDC_DEF_ACCEL     16'h0010
`define SMDC_DEF_DECAY     16'h07d0
`define SMDC_DEF_INIT      16'h0064
`define SMDC_DEF_DIV       16'h0001
`define SMDC_NPARAM        6
`define SMDC_P_JOG0        3'h0
`define SMDC_P_JOG1        3'h1
`define SMDC_P_ACCEL       3'h2
`define SMDC_P_DECAY       3'h3
`define SMDC_P_INIT        3'h4
`define SMDC_P_DIV         3'h5
`define SMDC_HOLD_0        2'h0
`define SMDC_HOLD_15       2'h1
`define SMDC_HOLD_50       2'h2
`define SMDC_HOLD_100      2'h3
`endif

/* smdc_pkg.sv */
/*
  Types for the step motor drive control block.
  Assumes the map header is compiled alongside.
*/
package smdc_pkg;
  typedef struct packed {
    logic       enable;
    logic       run;
    logic [1:0] hold_level;
    logic       fast_decay;
    logic [5:0] phase;
  } smdc_drive_t;

  typedef struct packed {
    logic       ccw_limit;
    logic       cw_limit;
    logic       speed_sel;
    logic       jog_cw;
    logic       jog_ccw;
  } smdc_jog_t;

  typedef enum logic [4:0] {
    SMDC_CMD   = 5'b00001,
    SMDC_HI    = 5'b00010,
    SMDC_LO    = 5'b00100,
    SMDC_EXEC  = 5'b01000,
    SMDC_REPLY = 5'b10000
  } smdc_cmd_state_t;
endpackage

/* smdc_top.sv */
/*
  Step motor drive control: step/direction or quadrature input, jog with
  ramping, limits, disable, microstep phase, run/hold current, decay
  select, serial parameter commands with non-volatile image ports.
  Assumes an external non-volatile store that returns the image at reset
  release and saves it on the save strobe; analog current loop outside.
*/
`timescale 1ns/1ps
`include "smdc_map.svh"
module smdc_top
  import smdc_pkg::*;
#(
  parameter int IDLE_CYCLES = `SMDC_IDLE_CYCLES,
  parameter int BIT_CYCLES  = `SMDC_BIT_CYCLES,
  parameter int RATE_WIN    = `SMDC_RATE_WIN,
  parameter bit ENCODER_OPT = 1'b0
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              step_i,
  input  wire logic              dir_i,
  input  wire logic              disable_n_i,
  input  wire logic [4:0]        jog_pins_i,
  input  wire logic [1:0]        resolution_select_pins_i,
  input  wire logic [1:0]        hold_level_select_pins_i,
  input  wire logic              rxd_i,
  input  wire logic [16*6-1:0]   nv_image_i,
  output logic                   txd_o,
  output logic [16*6-1:0]        nv_image_o,
  output logic                   nv_save_o,
  output smdc_drive_t            drive_o
);
  // Pins are asynchronous: two stages before use, jumper pins included
  logic [12:0] s1_q, s2_q;
  always_ff @(posedge clk_i) begin
    s1_q <= {step_i, dir_i, disable_n_i, jog_pins_i, rxd_i,
             resolution_select_pins_i, hold_level_select_pins_i};
    s2_q <= s1_q;
  end
  wire       step_s = s2_q[12];
  wire       dir_s  = s2_q[11];
  wire       en_s   = s2_q[10];
  smdc_jog_t jog_s;
  assign jog_s = s2_q[9:5];
  wire       rx_s   = s2_q[4];
  wire [1:0] res_s  = s2_q[3:2];
  wire [1:0] hold_s = s2_q[1:0];

  logic step_p_q, dir_p_q;
  always_ff @(posedge clk_i) begin
    step_p_q <= step_s;
    dir_p_q  <= dir_s;
  end

  // Parameter store, loaded from non-volatile image after reset release
  logic [15:0] par_q [`SMDC_NPARAM];
  logic [15:0] def_w [`SMDC_NPARAM];
  assign def_w[0] = `SMDC_DEF_JOG0;
  assign def_w[1] = `SMDC_DEF_JOG1;
  assign def_w[2] = `SMDC_DEF_ACCEL;
  assign def_w[3] = `SMDC_DEF_DECAY;
  assign def_w[4] = `SMDC_DEF_INIT;
  assign def_w[5] = `SMDC_DEF_DIV;

  // Step sources; quadrature decode of the two pins
  // Quadrature pin reuse
  wire a_e = step_s ^ step_p_q;
  wire b_e = dir_s ^ dir_p_q;
  wire q_step = ENCODER_OPT && (a_e || b_e);
  wire q_dir  = a_e ? (step_s ^ dir_s) : ~(step_s ^ dir_s);
  // Two-stage sampling at 40 MHz cannot miss 12 us pulses
  wire ext_step = ENCODER_OPT ? q_step : (step_s & ~step_p_q);
  wire ext_dir  = ENCODER_OPT ? q_dir : dir_s;

  // Jog ramp: rate in steps per second, accumulator turns it into steps
  // Jog direction mapping
  wire jog_act = jog_s.jog_ccw ^ jog_s.jog_cw;
  wire jog_dir = jog_s.jog_cw;  // 1 = clockwise
  wire [15:0] jog_tgt = jog_act ? (jog_s.speed_sel ? par_q[`SMDC_P_JOG1]
                                                    : par_q[`SMDC_P_JOG0]) : 16'h0000;
  logic [15:0] rate_q;
  logic [25:0] ms_q;
  logic [31:0] acc_q;
  wire  ms_tick = (ms_q == 26'((RATE_WIN / 1000) - 1));
  wire [15:0] acc_v = par_q[`SMDC_P_ACCEL];
  wire [15:0] rate_d =
    !ms_tick ? rate_q :
    (rate_q < jog_tgt) ? ((jog_tgt - rate_q > acc_v) ? rate_q + acc_v : jog_tgt) :
    (rate_q > jog_tgt) ? ((rate_q - jog_tgt > acc_v) ? rate_q - acc_v : jog_tgt) :
    rate_q;
  wire [31:0] acc_sum  = acc_q + 32'(rate_q);
  wire        jog_step = (acc_sum >= 32'(RATE_WIN));
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rate_q <= 16'h0000;
      ms_q   <= 26'h0;
      acc_q  <= 32'h0;
    end else begin
      ms_q   <= ms_tick ? 26'h0 : ms_q + 26'h1;
      rate_q <= (rate_q == 16'h0000 && jog_act && ms_tick) ? par_q[`SMDC_P_INIT] : rate_d;
      acc_q  <= jog_step ? acc_sum - 32'(RATE_WIN) : acc_sum;
    end
  end

  // Merge sources; limits gate by direction
  wire any_step = jog_act ? jog_step : ext_step;
  wire step_cw  = jog_act ? jog_dir : ext_dir;
  wire blk_ccw  = jog_s.ccw_limit & ~step_cw;
  wire blk_cw   = jog_s.cw_limit & step_cw;
  wire do_step  = any_step & ~blk_ccw & ~blk_cw;

  wire [5:0] inc = 6'h08 >> res_s;
  logic [5:0] phase_q;
  always_ff @(posedge clk_i) begin
    if (reset_i) phase_q <= 6'h00;
    else if (do_step) phase_q <= step_cw ? phase_q + inc : phase_q - inc;
  end

  // Run/hold current with idle timeout
  logic        run_q;
  logic [31:0] idle_q;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      run_q  <= 1'b0;
      idle_q <= 32'h0;
    end else if (do_step) begin
      run_q  <= 1'b1;
      idle_q <= 32'h0;
    end else if (run_q) begin
      idle_q <= idle_q + 32'h1;
      if (idle_q == 32'(IDLE_CYCLES - 1)) run_q <= 1'b0;
    end
  end

  // Step rate measured over a window of one second scaled down
  logic [31:0] win_q;
  logic [15:0] cnt_q, meas_q;
  wire win_end = (win_q == 32'((RATE_WIN >> `SMDC_RATE_SHIFT) - 1));
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      win_q <= 32'h0;
      cnt_q <= 16'h0;
      meas_q <= 16'h0;
    end else begin
      win_q <= win_end ? 32'h0 : win_q + 32'h1;
      if (win_end) begin
        meas_q <= cnt_q << `SMDC_RATE_SHIFT;
        cnt_q  <= 16'(do_step);
      end else if (do_step) begin
        cnt_q  <= cnt_q + 16'h1;
      end
    end
  end
  // Rate above threshold means fast decay
  wire fast_w = (meas_q > par_q[`SMDC_P_DECAY]);

  // Serial receiver and transmitter, 8N1
  // Start, eight data, stop
  logic [15:0] rb_q;
  logic [3:0]  rbit_q;
  logic [7:0]  rsh_q;
  logic        rbusy_q, rx_vld_q;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rb_q <= 16'h0; rbit_q <= 4'h0; rsh_q <= 8'h0; rbusy_q <= 1'b0; rx_vld_q <= 1'b0;
    end else begin
      rx_vld_q <= 1'b0;
      if (!rbusy_q) begin
        if (!rx_s) begin
          rbusy_q <= 1'b1;
          rb_q <= 16'(BIT_CYCLES / 2);
          rbit_q <= 4'h0;
        end
      end else if (rb_q != 16'h0) begin
        rb_q <= rb_q - 16'h1;
      end else begin
        rb_q <= 16'(BIT_CYCLES - 1);
        rbit_q <= rbit_q + 4'h1;
        if (rbit_q == 4'h0 && rx_s) rbusy_q <= 1'b0;  // False start
        else if (rbit_q >= 4'h1 && rbit_q <= 4'h8) rsh_q <= {rx_s, rsh_q[7:1]};
        else if (rbit_q == 4'h9) begin
          rbusy_q <= 1'b0;
          rx_vld_q <= rx_s;  // Framing error drops the byte
        end
      end
    end
  end

  logic [15:0] tb_q;
  logic [9:0]  tsh_q;
  logic [3:0]  tcnt_q;
  logic        tx_go, txd_q;
  logic [7:0]  tx_byte;
  wire  tx_idle = (tcnt_q == 4'h0);
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tb_q <= 16'h0; tsh_q <= 10'h3ff; tcnt_q <= 4'h0; txd_q <= 1'b1;
    end else if (tx_idle) begin
      txd_q <= 1'b1;
      if (tx_go) begin
        tsh_q <= {1'b1, tx_byte, 1'b0};
        tcnt_q <= 4'hb;
        tb_q <= 16'h0;
      end
    end else if (tb_q == 16'h0) begin
      // Last count only times the stop cell, so it lasts a full bit
      tcnt_q <= tcnt_q - 4'h1;
      tb_q <= 16'(BIT_CYCLES - 1);
      if (tcnt_q != 4'h1) begin
        txd_q <= tsh_q[0];
        tsh_q <= {1'b1, tsh_q[9:1]};
      end
    end else begin
      tb_q <= tb_q - 16'h1;
    end
  end

  // Image load one cycle after reset release
  logic load_q, loaded_q;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      load_q <= 1'b0; loaded_q <= 1'b0;
    end else begin
      load_q <= ~loaded_q;
      loaded_q <= 1'b1;
    end
  end

  // Command interpreter: letter, then high and low byte for value commands
  // Command set
  smdc_cmd_state_t st_q;
  logic [7:0]  cmd_q, hi_q;
  logic [2:0]  idx_q, rep_q;
  logic        rep_lo_q, save_q;
  wire is_val = (cmd_q == `SMDC_CMD_JOG) || (cmd_q == `SMDC_CMD_DECAY) ||
                (cmd_q == `SMDC_CMD_DIV) || (cmd_q == `SMDC_CMD_INIT) ||
                (cmd_q == `SMDC_CMD_ACCEL);
  wire [2:0] tgt_idx = (cmd_q == `SMDC_CMD_DECAY) ? `SMDC_P_DECAY :
                       (cmd_q == `SMDC_CMD_DIV)   ? `SMDC_P_DIV :
                       (cmd_q == `SMDC_CMD_INIT)  ? `SMDC_P_INIT :
                       (cmd_q == `SMDC_CMD_ACCEL) ? `SMDC_P_ACCEL : idx_q;
  wire [15:0] rep_w = par_q[rep_q];
  assign tx_byte = rep_lo_q ? rep_w[7:0] : rep_w[15:8];
  assign tx_go   = (st_q == SMDC_REPLY);
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_q <= SMDC_CMD; cmd_q <= 8'h00; hi_q <= 8'h00; idx_q <= 3'h0;
      rep_q <= 3'h0; rep_lo_q <= 1'b0; save_q <= 1'b0;
      // Cleared until the stored image arrives
      for (int i = 0; i < `SMDC_NPARAM; i++) par_q[i] <= 16'h0;
    end else begin
      save_q <= 1'b0;
      case (st_q)
        SMDC_CMD: if (rx_vld_q) begin
          cmd_q <= rsh_q;
          idx_q <= `SMDC_P_JOG0;
          st_q  <= SMDC_EXEC;
        end
        SMDC_HI: if (rx_vld_q) begin
          hi_q <= rsh_q;
          st_q <= SMDC_LO;
        end
        SMDC_LO: if (rx_vld_q) begin
          par_q[tgt_idx] <= {hi_q, rsh_q};
          if (cmd_q == `SMDC_CMD_JOG && idx_q == `SMDC_P_JOG0) begin
            idx_q <= `SMDC_P_JOG1;
            st_q  <= SMDC_HI;
          end else st_q <= SMDC_CMD;
        end
        SMDC_EXEC: begin
          st_q <= SMDC_CMD;
          if (is_val) st_q <= SMDC_HI;
          else if (cmd_q == `SMDC_CMD_CLEAR) begin
            for (int i = 0; i < `SMDC_NPARAM; i++) par_q[i] <= def_w[i];
          end else if (cmd_q == `SMDC_CMD_STORE) save_q <= 1'b1;
          else if (cmd_q == `SMDC_CMD_EXAM) begin
            rep_q <= 3'h0; rep_lo_q <= 1'b0; st_q <= SMDC_REPLY;
          end
        end
        SMDC_REPLY: if (tx_idle) begin
          rep_lo_q <= ~rep_lo_q;
          // Index stops at the last word so it never points past the store
          if (rep_lo_q) begin
            if (rep_q == 3'(`SMDC_NPARAM - 1)) st_q <= SMDC_CMD;
            else rep_q <= rep_q + 3'h1;
          end
        end
        default: st_q <= SMDC_CMD;
      endcase
      if (load_q) for (int i = 0; i < `SMDC_NPARAM; i++) par_q[i] <= nv_image_i[16*i +: 16];
    end
  end

  // Registered outputs
  logic [16*6-1:0] img_w;
  always_comb begin
    img_w = '0;
    for (int i = 0; i < `SMDC_NPARAM; i++) img_w[16*i +: 16] = par_q[i];
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      drive_o <= '0;
      txd_o <= 1'b1;
      nv_image_o <= '0;
      nv_save_o <= 1'b0;
    end else begin
      drive_o.enable     <= en_s;
      drive_o.run        <= run_q;
      drive_o.hold_level <= hold_s;
      drive_o.fast_decay <= fast_w;
      drive_o.phase      <= phase_q;
      txd_o      <= txd_q;
      nv_image_o <= img_w;
      nv_save_o  <= save_q;
    end
  end
endmodule

/* smdc_monitor.sv */
/* Port checker for the step motor drive control block.
   Assumes it is bound to smdc_top and sees only its ports. */
`timescale 1ns/1ps
module smdc_monitor
  import smdc_pkg::*;
#(
  parameter int IDLE_CYCLES = 20,
  parameter int BIT_CYCLES  = 16
) (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        step_i,
  input wire logic        dir_i,
  input wire logic        disable_n_i,
  input wire logic [4:0]  jog_pins_i,
  input wire logic [1:0]  resolution_select_pins_i,
  input wire logic [1:0]  hold_level_select_pins_i,
  input wire logic        txd_o,
  input wire logic        nv_save_o,
  input wire smdc_drive_t drive_o
);
  logic [5:0] ref_q;
  int         idle_q;
  int         low_q;
  logic       moved_q;
  wire        quiet = (jog_pins_i & 5'h03) == 5'h00;
  wire        free  = disable_n_i && (jog_pins_i & 5'h1b) == 5'h00;
  wire [5:0]  inc   = 6'h08 >> resolution_select_pins_i;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Idle time since any motion request; jog counts too, it may hold run current
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      idle_q  <= 0;
      low_q   <= 0;
      moved_q <= 1'b0;
      ref_q   <= 6'h00;
    end else begin
      idle_q  <= ($rose(step_i) || !quiet) ? 0 : idle_q + 1;
      low_q   <= txd_o ? 0 : low_q + 1;
      moved_q <= moved_q | $rose(step_i) | !quiet;
      if ($rose(step_i)) ref_q <= drive_o.phase;
    end
  end
  chk_disable_off: assert property ((!disable_n_i)[*6] |-> !drive_o.enable)
    else $error("power stage on while disabled");
  chk_hold_level: assert property ($stable(hold_level_select_pins_i)[*6] |->
    drive_o.hold_level == hold_level_select_pins_i)
    else $error("hold level differs from pins");
  chk_run_idle: assert property (idle_q > IDLE_CYCLES + 8 |-> !drive_o.run)
    else $error("run current kept after idle timeout");
  chk_run_on_step: assert property ($rose(step_i) && free |-> ##[1:8] drive_o.run)
    else $error("run current missing after step");
  chk_hold_start: assert property (!moved_q |-> !drive_o.run)
    else $error("run current before first step");
  chk_phase_inc: assert property ($rose(step_i) && free |=> ##[1:8]
    (drive_o.phase == ref_q + inc || drive_o.phase == ref_q - inc))
    else $error("phase moved by wrong increment");
  chk_ccw_block: assert property ($rose(step_i) && jog_pins_i[4] && !dir_i && quiet
    |=> $stable(drive_o.phase)[*8])
    else $error("ccw step passed the ccw limit");
  chk_cw_block: assert property ($rose(step_i) && jog_pins_i[3] && dir_i && quiet
    |=> $stable(drive_o.phase)[*8])
    else $error("cw step passed the cw limit");
  chk_save_pulse: assert property (nv_save_o |=> !nv_save_o)
    else $error("save strobe longer than one cycle");
  chk_start_bit: assert property ($rose(txd_o) |-> low_q >= BIT_CYCLES - 1)
    else $error("serial low cell shorter than a bit");
endmodule
bind smdc_top smdc_monitor #(
  .IDLE_CYCLES(IDLE_CYCLES),
  .BIT_CYCLES (BIT_CYCLES)
) u_smdc_monitor (
  .clk_i, .reset_i, .step_i, .dir_i, .disable_n_i, .jog_pins_i,
  .resolution_select_pins_i, .hold_level_select_pins_i, .txd_o, .nv_save_o, .drive_o
);

/* smdc_ctrl_model.sv */
/* Step and direction controller model: one step pulse per go request.
   Assumes go is raised for one clock while busy is low. */
`timescale 1ns/1ps
module smdc_ctrl_model #(
  parameter int HIGH_CYC = 8
) (
  input  wire logic clk_i,
  input  wire logic go_i,
  input  wire logic cw_i,
  output logic      step_o,
  output logic      dir_o,
  output logic      busy_o
);
  // Start values given at declaration so each output keeps one driver
  logic step_q = 1'b0;
  logic dir_q  = 1'b0;
  logic busy_q = 1'b0;
  int   cnt    = 0;
  assign step_o = step_q;
  assign dir_o  = dir_q;
  assign busy_o = busy_q;
  // Direction set before the step edge and held after it
  always @(posedge clk_i) begin
    if (go_i && !busy_q) begin
      dir_q  <= cw_i;
      busy_q <= 1'b1;
      cnt    <= 0;
    end else if (busy_q) begin
      cnt    <= cnt + 1;
      step_q <= cnt >= 1 && cnt < 1 + HIGH_CYC;
      busy_q <= cnt < 2 * HIGH_CYC + 1;
    end
  end
endmodule

/* smdc_top_tb.sv */
/* Self-checking bench for smdc_top with a step controller model.
   Assumes shortened idle, bit and rate parameters. */
`timescale 1ns/1ps
`include "smdc_map.svh"
module smdc_top_tb
  import smdc_pkg::*;
;
  localparam int BITC = 16;
  localparam int IDLE = 20;
  logic        clk_i, reset_i, step_i, dir_i, disable_n_i, rxd_i, txd_o, nv_save_o;
  logic        go, cw, busy;
  logic [4:0]  jog_pins_i;
  logic [1:0]  res_i, hold_i;
  logic [95:0] nv_in, nv_out;
  logic [15:0] par [6];
  logic [7:0]  rxb;
  logic [7:0]  rxq [$];
  logic [5:0]  phq [$];
  logic [5:0]  exp_ph, last_ph;
  smdc_drive_t drive_o;
  int          errors, n_compared, jog_dir, jog_steps, saves, seed;
  smdc_top #(.IDLE_CYCLES(IDLE), .BIT_CYCLES(BITC), .RATE_WIN(16000), .ENCODER_OPT(1'b0))
  u_smdc_top (.clk_i, .reset_i, .step_i, .dir_i, .disable_n_i, .jog_pins_i,
    .resolution_select_pins_i(res_i), .hold_level_select_pins_i(hold_i), .rxd_i,
    .nv_image_i(nv_in), .txd_o, .nv_image_o(nv_out), .nv_save_o, .drive_o);
  smdc_ctrl_model u_smdc_ctrl_model (.clk_i, .go_i(go), .cw_i(cw), .step_o(step_i),
    .dir_o(dir_i), .busy_o(busy));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic tick(int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic check(string what, logic [15:0] seen, logic [15:0] expv);
    n_compared++;
    if (seen !== expv) begin
      errors++;
      $display("Error %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // One step; the note is the signed phase move, a blocked step leaves none
  task automatic step(logic dir, logic blocked);
    int k;
    if (!blocked) phq.push_back(dir ? (6'h08 >> res_i) : 6'h00 - (6'h08 >> res_i));
    cw <= dir;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    for (k = 0; k < 100 && (k < 2 || busy); k++) @(posedge clk_i);
    if (busy) begin
      errors++;
      report_and_stop();
    end
    if (!blocked) check("run on step", drive_o.run, 16'h0001);
    tick(3);
  endtask
  // 8N1 byte on the receive pin, least significant bit first
  task automatic send(logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_i <= f[i];
      tick(BITC);
    end
  endtask
  // Examine: twelve reply bytes, high byte of each parameter first
  task automatic exam();
    int k;
    for (k = 0; k < 12; k++) rxq.push_back(k[0] ? par[k/2][7:0] : par[k/2][15:8]);
    send(`SMDC_CMD_EXAM);
    for (k = 0; k < 40000 && rxq.size() > 0; k++) @(posedge clk_i);
    if (rxq.size() > 0) begin
      errors++;
      report_and_stop();
    end
    $display("test examine done");
  endtask
  // Reply decoder: samples mid-cell and matches the oldest expected byte
  initial forever begin
    @(posedge clk_i);
    if (!reset_i && txd_o === 1'b0) begin
      tick(BITC / 2);
      for (int i = 0; i < 8; i++) begin
        tick(BITC);
        rxb[i] = txd_o;
      end
      tick(BITC);
      if (rxq.size() == 0) check("stray byte", {8'h00, rxb}, 16'hffff);
      else check("reply byte", {8'h00, rxb}, {8'h00, rxq.pop_front()});
    end
  end
  // Phase watcher: every change must match a note or the jog direction
  always @(posedge clk_i) begin
    if (nv_save_o === 1'b1) saves++;
    if (reset_i) begin
      last_ph <= 6'h00;
      exp_ph = 6'h00;
    end else if (drive_o.phase !== last_ph) begin
      last_ph <= drive_o.phase;
      if (jog_dir != 0) begin
        exp_ph = jog_dir > 0 ? exp_ph + (6'h08 >> res_i) : exp_ph - (6'h08 >> res_i);
        jog_steps++;
        check("jog phase", drive_o.phase, exp_ph);
      end else if (phq.size() == 0) check("stray phase", drive_o.phase, last_ph);
      else begin
        exp_ph = exp_ph + phq.pop_front();
        check("step phase", drive_o.phase, exp_ph);
      end
    end
  end
  // Watchdog: a hang ends the run as a failure
  initial begin
    repeat (100000) @(posedge clk_i);
    errors++;
    report_and_stop();
  end
  initial begin
    {errors, n_compared, jog_dir, jog_steps, saves} = '0;
    {reset_i, disable_n_i, rxd_i} = 3'h7;
    {go, cw, jog_pins_i, res_i, hold_i} = 11'h000;
    par = '{16'h9c40, 16'h9c40, 16'h0010, 16'h07d0, 16'h9c40, 16'h0001};
    nv_in = {par[5], par[4], par[3], par[2], par[1], par[0]};
    seed = $urandom(32'hbe2a2cfe);
    tick(12);
    reset_i <= 1'b0;
    tick(10);
    check("run after reset", drive_o.run, 16'h0000);
    check("enable", drive_o.enable, 16'h0001);
    for (int h = 0; h < 4; h++) begin
      hold_i <= 2'(h);
      tick(8);
      check("hold level", drive_o.hold_level, 16'(h));
    end
    disable_n_i <= 1'b0;
    tick(8);
    check("enable off", drive_o.enable, 16'h0000);
    disable_n_i <= 1'b1;
    $display("test static done");
    for (int i = 0; i < 16; i++) begin
      res_i <= 2'($urandom_range(3));
      tick(6);
      step(1'($urandom_range(1)), 1'b0);
    end
    tick(IDLE + 12);
    check("run after idle", drive_o.run, 16'h0000);
    jog_pins_i <= 5'h10;
    tick(6);
    step(1'b0, 1'b1);
    step(1'b1, 1'b0);
    jog_pins_i <= 5'h08;
    tick(6);
    step(1'b1, 1'b1);
    step(1'b0, 1'b0);
    check("notes left", 16'(phq.size()), 16'h0000);
    check("slow decay", drive_o.fast_decay, 16'h0000);
    $display("test steps done");
    jog_pins_i <= 5'h00;
    tick(6);
    jog_dir = -1;
    jog_pins_i <= 5'h01;
    tick(3000);
    check("fast decay", drive_o.fast_decay, 16'h0001);
    jog_pins_i <= 5'h00;
    tick(1200);
    jog_dir = 1;
    jog_pins_i <= 5'h06;
    tick(3000);
    jog_pins_i <= 5'h00;
    tick(1200);
    jog_dir = 0;
    check("jog steps", 16'(jog_steps >= 4), 16'h0001);
    jog_pins_i <= 5'h11;
    tick(3000);
    jog_pins_i <= 5'h00;
    $display("test jog done");
    send(`SMDC_CMD_JOG);
    par[0] = 16'($urandom);
    par[1] = 16'($urandom);
    for (int i = 0; i < 4; i++) send(i[0] ? par[i/2][7:0] : par[i/2][15:8]);
    exam();
    send(`SMDC_CMD_STORE);
    tick(40);
    check("save strobes", 16'(saves), 16'h0001);
    check("stored jog0", nv_out[15:0], par[0]);
    check("stored jog1", nv_out[31:16], par[1]);
    send(`SMDC_CMD_CLEAR);
    par = '{`SMDC_DEF_JOG0, `SMDC_DEF_JOG1, `SMDC_DEF_ACCEL, `SMDC_DEF_DECAY,
      `SMDC_DEF_INIT, `SMDC_DEF_DIV};
    exam();
    report_and_stop();
  end
endmodule
